// >>> nac_core.sv
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module nac_core #(
	parameter int DIV = nac_pkg::CYCLE_DIV
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Instruction stream
	input  wire logic [9:0]  instr_word,
	input  wire logic        instr_valid,
	input  wire logic [3:0]  ram_nibble_at_pointer,
	// Converter unit
	input  wire logic        conv_done_in,
	output logic             adc_start,
	output logic             comp_start,
	output logic             conversion_done_flag,
	// Core state
	output logic [3:0]       acc,
	output logic             carry_flag,
	output logic             skip_pending,
	output logic             instr_skipped,
	output logic             instr_taken,
	// Interrupt
	output logic             irq,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// Architectural state
	logic [3:0]  acc_q, acc_d;
	logic        carry_q, carry_d;
	logic        done_q, done_d;
	logic        skip_q, skip_d;
	logic [3:0]  ctrl_q, ctrl_d;
	logic        adc_q, comp_q;
	logic        skipped_q, taken_q;
	logic [2:0]  istat_q, istat_d;
	logic [2:0]  imask_q, imask_d;
	logic        irq_q;

	// Bus slave state
	logic        aw_full_q, w_full_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// Machine cycle enable
	logic        cyc_en;

	nac_cycle_divider #(
		.DIV (DIV)
	) nac_cycle_divider_inst (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (cyc_en)
	);

	// Decode; a fetched word is taken once per machine cycle
	nac_pkg::nac_op_t op;
	logic        fetch;
	logic        exec;
	logic        is_addi;

	assign fetch   = cyc_en && instr_valid;
	assign exec    = fetch && !skip_q;
	assign is_addi = (instr_word[9:4] == nac_pkg::OPC_ADDI_HI);

	assign op = !exec                               ? nac_pkg::OP_NONE   :
	            is_addi                             ? nac_pkg::OP_ADDI   :
	            (instr_word == nac_pkg::OPC_ADDM)   ? nac_pkg::OP_ADDM   :
	            (instr_word == nac_pkg::OPC_ADDMC)  ? nac_pkg::OP_ADDMC  :
	            (instr_word == nac_pkg::OPC_CSTART) ? nac_pkg::OP_CSTART :
	                                                  nac_pkg::OP_NONE;

	// Adder operand selection
	logic [3:0]  add_b;
	logic        add_cin;
	logic [3:0]  add_sum;
	logic        add_cout;

	assign add_b   = (op == nac_pkg::OP_ADDI) ? instr_word[3:0] : ram_nibble_at_pointer;
	assign add_cin = (op == nac_pkg::OP_ADDMC) ? carry_q : 1'b0;

	nac_nibble_adder #(
		.W (nac_pkg::NIB_W)
	) nac_nibble_adder_inst (
		.a    (acc_q),
		.b    (add_b),
		.cin  (add_cin),
		.sum  (add_sum),
		.cout (add_cout)
	);

	// Converter launch decode
	logic        launch;
	logic        mode_cmp;

	assign launch   = (op == nac_pkg::OP_CSTART);
	assign mode_cmp = ctrl_q[nac_pkg::CTRL_MODE_BIT];

	// Register write decode
	logic        wr_go;
	logic        wr_lane0;
	logic        wr_ctrl, wr_state, wr_istat, wr_imask, wr_hit;
	logic [7:0]  wbyte;

	assign wr_go    = aw_full_q && w_full_q && !bvalid_q;
	assign wr_lane0 = wr_go && w_strb_q[0];
	assign wbyte    = w_data_q[7:0];
	assign wr_ctrl  = wr_lane0 && (aw_addr_q[7:2] == nac_pkg::OFS_CTRL[7:2]);
	assign wr_state = wr_lane0 && (aw_addr_q[7:2] == nac_pkg::OFS_STATE[7:2]);
	assign wr_istat = wr_lane0 && (aw_addr_q[7:2] == nac_pkg::OFS_IRQ_STAT[7:2]);
	assign wr_imask = wr_lane0 && (aw_addr_q[7:2] == nac_pkg::OFS_IRQ_MASK[7:2]);
	assign wr_hit   = (aw_addr_q[7:2] == nac_pkg::OFS_CTRL[7:2]) ||
	                  (aw_addr_q[7:2] == nac_pkg::OFS_STATE[7:2]) ||
	                  (aw_addr_q[7:2] == nac_pkg::OFS_IRQ_STAT[7:2]) ||
	                  (aw_addr_q[7:2] == nac_pkg::OFS_IRQ_MASK[7:2]);

	// Accumulator and carry; an executing add beats a bus write to acc, and only ADDMC beats one to carry
	always_comb begin
		acc_d   = acc_q;
		carry_d = carry_q;
		if (wr_state) begin
			acc_d   = wbyte[nac_pkg::ST_ACC_LSB +: 4];
			carry_d = wbyte[nac_pkg::ST_CARRY];
		end
		unique case (op)
			nac_pkg::OP_ADDI: acc_d = add_sum;
			nac_pkg::OP_ADDM: acc_d = add_sum;
			nac_pkg::OP_ADDMC: begin
				acc_d   = add_sum;
				carry_d = add_cout;
			end
			nac_pkg::OP_CSTART: acc_d = acc_d;
			nac_pkg::OP_NONE:   acc_d = acc_d;
		endcase
	end

	// Skip: set by a non-overflowing immediate add, consumed by next fetch
	always_comb begin
		skip_d = skip_q;
		if (fetch && skip_q)
			skip_d = 1'b0;
		if (op == nac_pkg::OP_ADDI)
			skip_d = !add_cout;
	end

	// Done flag: a finishing conversion wins over the launch clear
	always_comb begin
		done_d = done_q;
		if (launch)
			done_d = 1'b0;
		if (conv_done_in)
			done_d = 1'b1;
	end

	// Converter control register
	assign ctrl_d = wr_ctrl ? wbyte[nac_pkg::CTRL_W-1:0] : ctrl_q;

	// Sticky events, write one to clear, set beats clear
	logic [2:0]  ev;

	assign ev[nac_pkg::IRQ_DONE]    = conv_done_in;
	assign ev[nac_pkg::IRQ_SKIPPED] = fetch && skip_q;
	assign ev[nac_pkg::IRQ_LAUNCH]  = launch;
	assign istat_d = (istat_q & ~(wr_istat ? wbyte[2:0] : 3'h0)) | ev;
	assign imask_d = wr_imask ? wbyte[2:0] : imask_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q   <= nac_pkg::RST_ACC;
			carry_q <= 1'b0;
			skip_q  <= 1'b0;
			taken_q <= 1'b0;
		end else begin
			acc_q   <= acc_d;
			carry_q <= carry_d;
			skip_q  <= skip_d;
			taken_q <= exec;
		end
	end

	// Converter launch pulses and flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_q    <= 1'b0;
			ctrl_q    <= nac_pkg::RST_CTRL;
			adc_q     <= 1'b0;
			comp_q    <= 1'b0;
			skipped_q <= 1'b0;
		end else begin
			done_q    <= done_d;
			ctrl_q    <= ctrl_d;
			adc_q     <= launch && !mode_cmp;
			comp_q    <= launch && mode_cmp;
			skipped_q <= fetch && skip_q;
		end
	end

	// Interrupt status, mask and level output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			istat_q <= nac_pkg::RST_IRQ;
			imask_q <= nac_pkg::RST_IRQ;
			irq_q   <= 1'b0;
		end else begin
			istat_q <= istat_d;
			imask_q <= imask_d;
			irq_q   <= |(istat_d & imask_d);
		end
	end

	// Write channel: address and data latched independently, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= nac_pkg::RESP_OKAY;
		end else begin
			awready_q <= !aw_full_q && !(s_axi_awvalid && awready_q) && !wr_go;
			wready_q  <= !w_full_q && !(s_axi_wvalid && wready_q) && !wr_go;
			if (s_axi_awvalid && awready_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? nac_pkg::RESP_OKAY : nac_pkg::RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read data selection; unmapped words read zero with an error
	logic        rd_hit;
	logic [31:0] rd_mux;
	logic [7:0]  st_byte;

	assign st_byte = {1'b0, skip_q, done_q, carry_q, acc_q};
	assign rd_hit  = (s_axi_araddr[7:2] == nac_pkg::OFS_CTRL[7:2]) ||
	                 (s_axi_araddr[7:2] == nac_pkg::OFS_STATE[7:2]) ||
	                 (s_axi_araddr[7:2] == nac_pkg::OFS_IRQ_STAT[7:2]) ||
	                 (s_axi_araddr[7:2] == nac_pkg::OFS_IRQ_MASK[7:2]);
	assign rd_mux  =
		(s_axi_araddr[7:2] == nac_pkg::OFS_CTRL[7:2])     ? {28'h0, ctrl_q}  :
		(s_axi_araddr[7:2] == nac_pkg::OFS_STATE[7:2])    ? {24'h0, st_byte} :
		(s_axi_araddr[7:2] == nac_pkg::OFS_IRQ_STAT[7:2]) ? {29'h0, istat_q} :
		(s_axi_araddr[7:2] == nac_pkg::OFS_IRQ_MASK[7:2]) ? {29'h0, imask_q} :
		                                                    nac_pkg::RST_RDATA;

	// Read channel: one read under way, data held until taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= nac_pkg::RST_RDATA;
			rresp_q   <= nac_pkg::RESP_OKAY;
		end else begin
			arready_q <= !rvalid_q && !(s_axi_arvalid && arready_q);
			if (s_axi_arvalid && arready_q) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_mux;
				rresp_q  <= rd_hit ? nac_pkg::RESP_OKAY : nac_pkg::RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Outputs straight from flops
	assign acc                  = acc_q;
	assign carry_flag           = carry_q;
	assign conversion_done_flag = done_q;
	assign skip_pending         = skip_q;
	assign instr_skipped        = skipped_q;
	assign instr_taken          = taken_q;
	assign adc_start            = adc_q;
	assign comp_start           = comp_q;
	assign irq                  = irq_q;
	assign s_axi_awready        = awready_q;
	assign s_axi_wready         = wready_q;
	assign s_axi_bvalid         = bvalid_q;
	assign s_axi_bresp          = bresp_q;
	assign s_axi_arready        = arready_q;
	assign s_axi_rvalid         = rvalid_q;
	assign s_axi_rdata          = rdata_q;
	assign s_axi_rresp          = rresp_q;

endmodule : nac_core

// >>> nac_core_asserts.sv
`timescale 1ns/1ps
module nac_core_asserts #(
	parameter int DIV = 1
) (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Instruction side
	input wire logic [9:0] instr_word,
	input wire logic       instr_valid,
	input wire logic [3:0] ram_nibble_at_pointer,
	// Converter side
	input wire logic       conv_done_in,
	input wire logic       adc_start,
	input wire logic       comp_start,
	input wire logic       conversion_done_flag,
	// Core state
	input wire logic [3:0] acc,
	input wire logic       carry_flag,
	input wire logic       skip_pending,
	input wire logic       instr_skipped,
	input wire logic       instr_taken
);
	// Decode of the word taken at this edge; valid for a tick on every edge
	wire       ex   = instr_valid & ~skip_pending;
	wire       addi = ex & (instr_word[9:4] == nac_pkg::OPC_ADDI_HI);
	wire       addm = ex & (instr_word == nac_pkg::OPC_ADDM);
	wire       addc = ex & (instr_word == nac_pkg::OPC_ADDMC);
	wire       cst  = ex & (instr_word == nac_pkg::OPC_CSTART);
	wire [4:0] isum = acc + instr_word[3:0];
	wire [3:0] msum = acc + ram_nibble_at_pointer;
	wire [4:0] csum = acc + ram_nibble_at_pointer + carry_flag;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_sum; addi |=> acc == $past(isum[3:0]); endproperty
	a_sum: assert property (p_sum) else $error("immediate sum");
	property p_iskip; addi |=> skip_pending == !$past(isum[4]) && $stable(carry_flag); endproperty
	a_iskip: assert property (p_iskip) else $error("immediate skip");
	property p_addm; addm |=> acc == $past(msum) && $stable(carry_flag); endproperty
	a_addm: assert property (p_addm) else $error("memory add");
	property p_addc; addc |=> {carry_flag, acc} == $past(csum); endproperty
	a_addc: assert property (p_addc) else $error("carry add");
	property p_clr; cst && !conv_done_in |=> !conversion_done_flag && (adc_start ^ comp_start); endproperty
	a_clr: assert property (p_clr) else $error("launch");
	property p_cause; adc_start || comp_start |-> $past(cst); endproperty
	a_cause: assert property (p_cause) else $error("stray start");
	property p_one; ex |=> instr_taken && !instr_skipped; endproperty
	a_one: assert property (p_one) else $error("one cycle");
	property p_drop; instr_valid && skip_pending |=> instr_skipped && !instr_taken && !skip_pending; endproperty
	a_drop: assert property (p_drop) else $error("discard");

	// Main scenarios reached
	c_ovf: cover property (addi && isum[4]);
	c_comp: cover property (comp_start);
	c_skip: cover property (instr_skipped);
endmodule : nac_core_asserts

bind nac_core nac_core_asserts #(.DIV(DIV)) nac_core_asserts_inst (.aclk, .aresetn, .instr_word,
	.instr_valid, .ram_nibble_at_pointer, .conv_done_in, .adc_start, .comp_start,
	.conversion_done_flag, .acc, .carry_flag, .skip_pending, .instr_skipped, .instr_taken);

// >>> nac_core_tb_top.sv
`timescale 1ns/1ps
module nac_core_tb_top;
	logic        aclk, aresetn, instr_valid, slow, conv_done_in, cf, sk;
	logic        adc_start, comp_start, conversion_done_flag, carry_flag, irq;
	logic        skip_pending, instr_skipped, instr_taken;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [3:0]  acc, ram_nibble_at_pointer, data_pointer, s_axi_wstrb, ac;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [9:0]  instr_word, w;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, rv;
	int          bad_count, compares, seed, i;

	nac_core nac_core_inst (
		.aclk (aclk), .aresetn (aresetn), .instr_word (instr_word), .instr_valid (instr_valid),
		.ram_nibble_at_pointer (ram_nibble_at_pointer), .conv_done_in (conv_done_in),
		.adc_start (adc_start), .comp_start (comp_start), .conversion_done_flag (conversion_done_flag),
		.acc (acc), .carry_flag (carry_flag), .skip_pending (skip_pending),
		.instr_skipped (instr_skipped), .instr_taken (instr_taken), .irq (irq),
		.s_axi_awaddr (s_axi_awaddr), .s_axi_awvalid (s_axi_awvalid), .s_axi_awready (s_axi_awready),
		.s_axi_wdata (s_axi_wdata), .s_axi_wstrb (s_axi_wstrb), .s_axi_wvalid (s_axi_wvalid),
		.s_axi_wready (s_axi_wready), .s_axi_bresp (s_axi_bresp), .s_axi_bvalid (s_axi_bvalid),
		.s_axi_bready (s_axi_bready), .s_axi_araddr (s_axi_araddr), .s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready), .s_axi_rdata (s_axi_rdata), .s_axi_rresp (s_axi_rresp),
		.s_axi_rvalid (s_axi_rvalid), .s_axi_rready (s_axi_rready)
	);
	nac_far_model nac_far_model_inst (
		.aclk (aclk), .aresetn (aresetn), .slow (slow), .data_pointer (data_pointer),
		.ram_nibble_at_pointer (ram_nibble_at_pointer), .adc_start (adc_start),
		.comp_start (comp_start), .conv_done_in (conv_done_in)
	);

	// 25 MHz clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Compare and count
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// Write: both channels offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		r = s_axi_rresp;
		d = s_axi_rdata;
	endtask : rd

	// Expected {skip, carry, acc} after one executed word
	function automatic logic [5:0] nx(input logic [9:0] wd, input logic [3:0] a, input logic c,
			input logic [3:0] m);
		logic [4:0] s;
		if (wd[9:4] == nac_pkg::OPC_ADDI_HI) begin
			s = a + wd[3:0];
			return {~s[4], c, s[3:0]};
		end
		s = a + m;
		if (wd == nac_pkg::OPC_ADDM) return {1'b0, c, s[3:0]};
		s = a + m + c;
		if (wd == nac_pkg::OPC_ADDMC) return {1'b0, s};
		return {1'b0, c, a};
	endfunction : nx

	// One fetch, checked against the bench's own state
	task automatic step(input logic [9:0] wd, input logic [3:0] p);
		logic [5:0] e;
		e = sk ? {1'b0, cf, ac} : nx(wd, ac, cf, p * 4'h7 + 4'h3);
		@(posedge aclk);
		instr_word <= wd;
		data_pointer <= p;
		instr_valid <= 1'b1;
		@(posedge aclk);
		instr_valid <= 1'b0;
		#1;
		chk(instr_skipped, sk);
		chk(instr_taken, !sk);
		{sk, cf, ac} = e;
		chk({skip_pending, carry_flag, acc}, e);
	endtask : step

	task automatic setst(input logic [4:0] v);
		wr(nac_pkg::OFS_STATE, {27'h0, v});
		{cf, ac} = v;
	endtask : setst

	// Main sequence
	initial begin
		seed = 32'h1de9;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{instr_valid, slow, aresetn, cf, sk, ac} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, instr_word, data_pointer} = '0;
		s_axi_wstrb = 4'hf;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, unmapped place refused
		for (i = 0; i < 5; i++) begin
			rd(8'(i * 4));
			chk({r, d}, {(i == 4) ? nac_pkg::RESP_SLVERR : nac_pkg::RESP_OKAY, 32'h0});
		end
		wr(8'h10, 32'h1);
		chk(r, nac_pkg::RESP_SLVERR);
		wr(nac_pkg::OFS_STATE, 32'h7f);
		rd(nac_pkg::OFS_STATE);
		chk(d, 32'h1f);
		$display("register test done");
		setst(5'h0f);
		step({nac_pkg::OPC_ADDI_HI, 4'h1}, 4'h0);
		setst(5'h10);
		step({nac_pkg::OPC_ADDI_HI, 4'h0}, 4'h0);
		step(nac_pkg::OPC_ADDM, 4'h5);
		setst(5'h1f);
		step(nac_pkg::OPC_ADDMC, 4'h2);
		step(nac_pkg::OPC_ADDM, 4'h4);
		// Random stream, raw words included
		for (i = 0; i < 80; i++) begin
			rv = $random(seed);
			w = (rv[5:4] == 2'h0) ? {nac_pkg::OPC_ADDI_HI, rv[3:0]} : (rv[5:4] == 2'h1) ?
				nac_pkg::OPC_ADDM : (rv[5:4] == 2'h2) ? nac_pkg::OPC_ADDMC : rv[15:6];
			step(w, rv[19:16]);
		end
		$display("instruction test done");
		for (i = 0; i < 2; i++) begin
			slow <= i[0];
			// Spare word eats a pending skip before the status clear
			step(10'h000, 4'h0);
			wr(nac_pkg::OFS_IRQ_STAT, 32'h7);
			wr(nac_pkg::OFS_IRQ_MASK, {31'h0, ~i[0]});
			wr(nac_pkg::OFS_CTRL, {28'h0, i[0], 3'h0});
			step(nac_pkg::OPC_CSTART, 4'h0);
			chk({comp_start, adc_start}, i[0] ? 2'h2 : 2'h1);
			chk(conversion_done_flag, 1'b0);
			repeat (20) @(posedge aclk);
			#1;
			chk({irq, conversion_done_flag}, {~i[0], 1'b1});
			rd(nac_pkg::OFS_IRQ_STAT);
			chk(d, 32'h5);
			wr(nac_pkg::OFS_IRQ_STAT, 32'h1);
			rd(nac_pkg::OFS_IRQ_STAT);
			chk({irq, d}, 33'h4);
		end
		$display("converter test done");
		test_done();
	end

	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		test_done();
	end
endmodule : nac_core_tb_top

// >>> nac_cycle_divider.sv
`timescale 1ns/1ps
module nac_cycle_divider #(
	parameter int DIV = 1
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Machine cycle enable
	output logic      tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_q;
	logic          tick_q;
	logic          wrap;

	assign wrap = (cnt_q == LAST);
	assign tick = tick_q;

	// Free-running count; tick is one clock wide when DIV is above 1, held high when DIV is 1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= '0;
			// Undivided rate ticks from the first edge after release
			tick_q <= (DIV == 1);
		end else begin
			cnt_q  <= wrap ? '0 : cnt_q + CW'(1);
			tick_q <= wrap;
		end
	end

endmodule : nac_cycle_divider

// >>> nac_far_model.sv
`timescale 1ns/1ps
module nac_far_model (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Converter speed select
	input wire logic       slow,
	// Data RAM
	input wire logic [3:0] data_pointer,
	output logic     [3:0] ram_nibble_at_pointer,
	// Converter
	input wire logic       adc_start,
	input wire logic       comp_start,
	output logic           conv_done_in
);
	logic [3:0] cnt_q;

	// Fixed RAM pattern, so the bench can predict operands
	assign ram_nibble_at_pointer = data_pointer * 4'h7 + 4'h3;
	// Done pulses once when the busy count runs out
	assign conv_done_in = (cnt_q == 4'h1);

	// Busy time, short or long
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_q <= 4'h0;
		else if (adc_start | comp_start)
			cnt_q <= slow ? 4'hc : 4'h2;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
endmodule : nac_far_model

// >>> nac_nibble_adder.sv
`timescale 1ns/1ps
module nac_nibble_adder #(
	parameter int W = 4
) (
	// Operands
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	input  wire logic         cin,
	// Result
	output logic      [W-1:0] sum,
	output logic              cout
);

	logic [W:0] full;

	// Fifth bit of the wide sum is the carry
	assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
	assign sum  = full[W-1:0];
	assign cout = full[W];

endmodule : nac_nibble_adder

// >>> nac_pkg.sv
package nac_pkg;

	// Operand widths
	localparam int NIB_W  = 4;
	localparam int INSTR_W = 10;

	// Instruction encodings (10-bit program words)
	localparam logic [5:0] OPC_ADDI_HI = 6'h06;
	localparam logic [9:0] OPC_ADDM    = 10'h00a;
	localparam logic [9:0] OPC_ADDMC   = 10'h00b;
	localparam logic [9:0] OPC_CSTART  = 10'h29f;

	// Converter control register fields
	localparam int CTRL_MODE_BIT = 3;
	localparam int CTRL_W        = 4;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATE    = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;

	// State register fields
	localparam int ST_ACC_LSB  = 0;
	localparam int ST_CARRY    = 4;
	localparam int ST_DONE     = 5;
	localparam int ST_SKIP     = 6;

	// Interrupt event bits
	localparam int IRQ_W       = 3;
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_SKIPPED = 1;
	localparam int IRQ_LAUNCH  = 2;

	// Values after reset
	localparam logic [3:0] RST_ACC   = 4'h0;
	localparam logic [3:0] RST_CTRL  = 4'h0;
	localparam logic [2:0] RST_IRQ   = 3'h0;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// Clock cycles per machine cycle
	localparam int CYCLE_DIV = 1;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Decoded instruction kind
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADDI,
		OP_ADDM,
		OP_ADDMC,
		OP_CSTART
	} nac_op_t;

endpackage : nac_pkg
